// >>> rtl/phm_mode_ctrl.sv
// phy operating mode, duplex, power-save control with serial line coding
//
// The address map and the AHB-Lite slave port were chosen for this implementation.
`timescale 1ns/1ps
// Behaviour
// - at 10 Mbit with 100-Mbit power save set, 100 Mbit modules are off
// - at 100 Mbit with 10-Mbit power save set, 10 Mbit modules are off
// - bit 19.0 clear keeps 100 Mbit modules on; set gates them at 10 Mbit
// - bit 19.1 clear keeps 10 Mbit modules on; set gates them at 100 Mbit
// - bit 0.12 enables auto-negotiation when set, disables when clear
// - negotiation picks the best mode common to both ends, 10 Mbit half duplex if none is common
// - nibbles are serialised on transmit and reassembled on receive
// - 100 Mbit uses 4B/5B, scrambling, NRZI and MLT-3, inverted on receive
// - 10 Mbit uses Manchester coding on both directions
// - half and full duplex at both speeds; full duplex runs both paths at once
// - 10 Mbit full duplex: no transmit loopback and no SQE test
// - full duplex: carrier only from receive, collision never asserted
// - half duplex: carrier on transmit or receive, collision on overlap
module phm_mode_ctrl (
    input wire logic mclk,
    input wire logic rstn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic [31:0] hrdata,
    output logic hresp,
    input wire logic lineClk,
    input wire phm_pkg::phm_mii_tx_t miiTx,
    output logic txNibbleReq,
    output phm_pkg::phm_mii_rx_t miiRx,
    input wire phm_pkg::phm_line_t lineRx,
    output phm_pkg::phm_line_t lineTx,
    input wire logic [3:0] partnerAbil,
    output logic mod100On,
    output logic mod10On,
    output logic linkSpeed100,
    output logic linkFullDup
);
    phm_pkg::phm_state_t q;
    phm_pkg::phm_state_t n;
    logic lineTick;
    logic loopMode;
    logic addrTake;
    logic lfsrBit;
    logic scr;
    logic lvlBit;
    logic [3:0] common;
    logic [3:0] lastCnt;
    logic [4:0] shNew;

    // 4b to 5b symbol table
    function automatic logic [4:0] enc5(input logic [3:0] d);
        logic [4:0] c;
        case (d)
            4'h0: c = 5'h1E;
            4'h1: c = 5'h09;
            4'h2: c = 5'h14;
            4'h3: c = 5'h15;
            4'h4: c = 5'h0A;
            4'h5: c = 5'h0B;
            4'h6: c = 5'h0E;
            4'h7: c = 5'h0F;
            4'h8: c = 5'h12;
            4'h9: c = 5'h13;
            4'hA: c = 5'h16;
            4'hB: c = 5'h17;
            4'hC: c = 5'h1A;
            4'hD: c = 5'h1B;
            4'hE: c = 5'h1C;
            default: c = 5'h1D;
        endcase
        return c;
    endfunction

    // inverse table by search; unknown codes give zero
    function automatic logic [3:0] dec4(input logic [4:0] c);
        logic [3:0] d;
        d = 4'h0;
        for (int i = 0; i < 16; i++) begin
            if (enc5(4'(i)) == c) begin
                d = 4'(i);
            end
        end
        return d;
    endfunction

    // mlt-3 state to line level: 1 is plus, 3 is minus
    function automatic phm_pkg::phm_line_t mltLine(input logic [1:0] s);
        phm_pkg::phm_line_t l;
        l.p = (s == 2'h1);
        l.n = (s == 2'h3);
        return l;
    endfunction

    // register read mux, also used for the write-forwarded view
    function automatic logic [31:0] readReg(input phm_pkg::phm_state_t s,
                                            input logic [7:0] a);
        logic [31:0] r;
        phm_pkg::phm_status_t st;
        r = 32'h0000_0000;
        st = '{rxAct: s.rxAct, txActive: s.txActive, col: s.col, crs: s.crs,
               partner: s.partS2, mod10On: s.mod10On, mod100On: s.mod100On,
               fullDup: s.fullDup, speed100: s.speed100};
        case (a)
            phm_pkg::ADDR_CTRL: begin
                r[phm_pkg::CTRL_AN_BIT] = s.anEnable;
                r[phm_pkg::CTRL_SPEED_BIT] = s.ctlSpeed100;
                r[phm_pkg::CTRL_DUP_BIT] = s.ctlFullDup;
            end
            phm_pkg::ADDR_ADV: r[3:0] = s.adv;
            phm_pkg::ADDR_STAT: r[$bits(st)-1:0] = st;
            phm_pkg::ADDR_EXT2: begin
                r[phm_pkg::EXT2_PS100_BIT] = s.ps100;
                r[phm_pkg::EXT2_PS10_BIT] = s.ps10;
            end
            default: r = 32'h0000_0000;
        endcase
        return r;
    endfunction

    always_comb begin
        n = q;
        lineTick = q.lineS2 & ~q.linePrev;
        loopMode = ~q.speed100 & ~q.fullDup;
        addrTake = hsel & hready & htrans[1];
        lfsrBit = 1'b0;
        scr = 1'b0;
        lvlBit = 1'b0;
        shNew = q.rxSh;
        common = q.adv & q.partS2;
        lastCnt = q.speed100 ? phm_pkg::SYM100_LAST : phm_pkg::SYM10_LAST;
        n.txReq = 1'b0;
        // two-stage synchronisers for every pin from outside mclk
        n.lineS1 = lineClk;
        n.lineS2 = q.lineS1;
        n.linePrev = q.lineS2;
        n.txS1 = miiTx;
        n.txS2 = q.txS1;
        n.rxLineS1 = lineRx;
        n.rxLineS2 = q.rxLineS1;
        n.partS1 = partnerAbil;
        n.partS2 = q.partS1;
        // bus data phase write, then forwarded into the read of the next address
        if (q.wrPend) begin
            case (q.wrAddr)
                phm_pkg::ADDR_CTRL: begin
                    n.anEnable = hwdata[phm_pkg::CTRL_AN_BIT];
                    n.ctlSpeed100 = hwdata[phm_pkg::CTRL_SPEED_BIT];
                    n.ctlFullDup = hwdata[phm_pkg::CTRL_DUP_BIT];
                end
                phm_pkg::ADDR_ADV: n.adv = hwdata[3:0];
                phm_pkg::ADDR_EXT2: begin
                    n.ps100 = hwdata[phm_pkg::EXT2_PS100_BIT];
                    n.ps10 = hwdata[phm_pkg::EXT2_PS10_BIT];
                end
                default: n.wrPend = 1'b0;
            endcase
        end
        n.wrPend = addrTake & hwrite;
        n.wrAddr = haddr[7:0];
        if (addrTake & ~hwrite) begin
            n.hrdata = readReg(n, haddr[7:0]);
        end
        // speed and duplex resolution, best common ability first
        if (q.anEnable) begin
            if (common[phm_pkg::ABIL_100FD]) begin
                n.speed100 = 1'b1;
                n.fullDup = 1'b1;
            end else if (common[phm_pkg::ABIL_100HD]) begin
                n.speed100 = 1'b1;
                n.fullDup = 1'b0;
            end else begin
                n.speed100 = 1'b0;
                n.fullDup = common[phm_pkg::ABIL_10FD];
            end
        end else begin
            n.speed100 = q.ctlSpeed100;
            n.fullDup = q.ctlFullDup;
        end
        // power gating of the unused speed's modules
        n.mod100On = ~(~q.speed100 & q.ps100);
        n.mod10On = ~(q.speed100 & q.ps10);
        // transmit path, one bit or half-bit per line tick
        if (lineTick) begin
            if (q.sqeCnt != 4'h0) begin
                n.sqeCnt = q.sqeCnt - 4'h1;
            end
            if (!q.txActive) begin
                n.txLine = '{p: 1'b0, n: 1'b0};
                if (q.txS2.txEn) begin
                    // start marker level gives the receiver its alignment
                    n.txActive = 1'b1;
                    n.txCnt = 4'h0;
                    n.txSh = q.speed100 ? enc5(q.txS2.txd) : {q.txS2.txd, 1'b0};
                    n.txReq = 1'b1;
                    n.txLfsr = phm_pkg::LFSR_SEED;
                    n.mlt = 2'h1;
                    n.txLine = '{p: 1'b1, n: 1'b0};
                    if (loopMode) begin
                        n.rxd = q.txS2.txd;
                        n.rxDv = 1'b1;
                    end
                end
            end else if (q.txStop) begin
                // end marker: both legs high, never a data level
                n.txActive = 1'b0;
                n.txStop = 1'b0;
                n.txLine = '{p: 1'b1, n: 1'b1};
                n.mlt = 2'h0;
                if (loopMode) begin
                    n.sqeCnt = phm_pkg::SQE_TICKS;
                end
            end else begin
                if (q.speed100) begin
                    lfsrBit = q.txLfsr[10] ^ q.txLfsr[8];
                    n.txLfsr = {q.txLfsr[9:0], lfsrBit};
                    scr = q.txSh[4] ^ lfsrBit;
                    n.mlt = q.mlt + {1'b0, scr};
                    n.txLine = mltLine(n.mlt);
                    n.txSh = {q.txSh[3:0], 1'b0};
                end else begin
                    // first half carries the inverse, second half the bit
                    lvlBit = q.txCnt[0] ? q.txSh[4] : ~q.txSh[4];
                    n.txLine = '{p: lvlBit, n: ~lvlBit};
                    if (q.txCnt[0]) begin
                        n.txSh = {q.txSh[3:0], 1'b0};
                    end
                end
                n.txCnt = q.txCnt + 4'h1;
                if (q.txCnt == lastCnt) begin
                    n.txCnt = 4'h0;
                    if (q.txS2.txEn) begin
                        n.txSh = q.speed100 ? enc5(q.txS2.txd) : {q.txS2.txd, 1'b0};
                        n.txReq = 1'b1;
                        if (loopMode) begin
                            n.rxd = q.txS2.txd;
                            n.rxDv = 1'b1;
                        end
                    end else begin
                        n.txStop = 1'b1;
                    end
                end
            end
        end
        // receive path runs beside transmit, so full duplex needs nothing extra
        if (lineTick) begin
            n.rxPrev = q.rxLineS2;
            if (!q.rxAct) begin
                if (q.rxLineS2 == 2'h2 || q.rxLineS2 == 2'h1) begin
                    n.rxAct = 1'b1;
                    n.rxCnt = 4'h0;
                    n.rxLfsr = phm_pkg::LFSR_SEED;
                end
            end else if (q.rxLineS2 == 2'h3) begin
                n.rxAct = 1'b0;
                n.rxDv = 1'b0;
            end else if (q.speed100) begin
                // every mlt-3 level change is a one after nrzi
                lfsrBit = q.rxLfsr[10] ^ q.rxLfsr[8];
                n.rxLfsr = {q.rxLfsr[9:0], lfsrBit};
                shNew = {q.rxSh[3:0], (q.rxLineS2 != q.rxPrev) ^ lfsrBit};
                n.rxSh = shNew;
                n.rxCnt = q.rxCnt + 4'h1;
                if (q.rxCnt == phm_pkg::SYM100_LAST) begin
                    n.rxd = dec4(shNew);
                    n.rxDv = 1'b1;
                    n.rxCnt = 4'h0;
                end
            end else begin
                if (q.rxCnt[0]) begin
                    shNew = {q.rxSh[3:0], q.rxLineS2.p};
                    n.rxSh = shNew;
                end
                n.rxCnt = q.rxCnt + 4'h1;
                if (q.rxCnt == phm_pkg::SYM10_LAST) begin
                    n.rxd = shNew[3:0];
                    n.rxDv = 1'b1;
                    n.rxCnt = 4'h0;
                end
            end
        end
        // loopback echo only lasts while a 10 Mbit half-duplex transmit runs
        if (!q.rxAct && !n.rxAct && !(loopMode && n.txActive)) begin
            n.rxDv = 1'b0;
        end
        // gated 100 Mbit scramblers hold their seed, saving toggles; nothing is held for 10 Mbit
        if (!q.mod100On) begin
            n.txLfsr = phm_pkg::LFSR_SEED;
            n.rxLfsr = phm_pkg::LFSR_SEED;
        end
        // carrier and collision
        if (q.fullDup) begin
            n.crs = q.rxAct;
            n.col = 1'b0;
        end else begin
            n.crs = q.txActive | q.rxAct;
            n.col = (q.txActive & q.rxAct) | (q.sqeCnt != 4'h0);
        end
    end

    // single state register
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            q <= '0;
            q.anEnable <= phm_pkg::CTRL_AN_RST;
            q.ctlSpeed100 <= phm_pkg::CTRL_SPEED_RST;
            q.ctlFullDup <= phm_pkg::CTRL_DUP_RST;
            q.adv <= phm_pkg::ADV_RST;
            q.ps100 <= phm_pkg::PS_RST;
            q.ps10 <= phm_pkg::PS_RST;
            q.txLfsr <= phm_pkg::LFSR_SEED;
            q.rxLfsr <= phm_pkg::LFSR_SEED;
        end else begin
            q <= n;
        end
    end

    // zero-wait slave, always okay
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = q.hrdata;
    assign txNibbleReq = q.txReq;
    assign miiRx = '{rxd: q.rxd, rxDv: q.rxDv, crs: q.crs, col: q.col};
    assign lineTx = q.txLine;
    assign mod100On = q.mod100On;
    assign mod10On = q.mod10On;
    assign linkSpeed100 = q.speed100;
    assign linkFullDup = q.fullDup;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rstn);

    sequence txStartSeq;
        lineTick && !q.txActive && q.txS2.txEn;
    endsequence
    sequence txOpenSeq;
        q.txActive && q.txReq;
    endsequence

    a_gate_100 : assert property ((!q.speed100 && q.ps100) |=> !mod100On)
        else $error("100M modules not gated at 10M");
    a_keep_100 : assert property (!q.ps100 |=> mod100On)
        else $error("100M modules gated with save off");
    a_gate_10 : assert property ((q.speed100 && q.ps10) |=> !mod10On)
        else $error("10M modules not gated at 100M");
    a_an_manual : assert property (!q.anEnable |=> linkSpeed100 == $past(q.ctlSpeed100))
        else $error("manual speed not applied");
    a_an_best : assert property ((q.anEnable && common[3]) |=> (linkSpeed100 && linkFullDup))
        else $error("best common mode not chosen");
    a_tx_start : assert property (txStartSeq |=> txOpenSeq)
        else $error("frame start did not take a nibble");
    a_fd_nocol : assert property (q.fullDup |=> !miiRx.col)
        else $error("collision in full duplex");
    a_fd_crs : assert property (q.fullDup |=> miiRx.crs == $past(q.rxAct))
        else $error("carrier not from receive only");
    a_hd_crs : assert property ((!q.fullDup && q.txActive) ##1 !q.fullDup |-> miiRx.crs)
        else $error("carrier missing during transmit");
    a_fd_nosqe : assert property ((q.fullDup && q.sqeCnt == 4'h0) |=> q.sqeCnt == 4'h0)
        else $error("sqe test in full duplex");
endmodule

// >>> common/phm_pkg.sv
// package for the phy mode, duplex and power-save control block
package phm_pkg;
    // register indices; byte address is four times the index
    localparam int REG_CTRL_IDX = 0;
    localparam int REG_ADV_IDX = 4;
    localparam int REG_STAT_IDX = 17;
    localparam int REG_EXT2_IDX = 19;
    localparam logic [7:0] ADDR_CTRL = 8'(REG_CTRL_IDX * 4);
    localparam logic [7:0] ADDR_ADV = 8'(REG_ADV_IDX * 4);
    localparam logic [7:0] ADDR_STAT = 8'(REG_STAT_IDX * 4);
    localparam logic [7:0] ADDR_EXT2 = 8'(REG_EXT2_IDX * 4);
    // field positions
    localparam int CTRL_AN_BIT = 12;
    localparam int CTRL_SPEED_BIT = 13;
    localparam int CTRL_DUP_BIT = 8;
    localparam int EXT2_PS100_BIT = 0;
    localparam int EXT2_PS10_BIT = 1;
    localparam int ABIL_100FD = 3;
    localparam int ABIL_100HD = 2;
    localparam int ABIL_10FD = 1;
    // values after reset
    localparam logic CTRL_AN_RST = 1'h1;
    localparam logic CTRL_SPEED_RST = 1'h1;
    localparam logic CTRL_DUP_RST = 1'h0;
    localparam logic [3:0] ADV_RST = 4'hF;
    localparam logic PS_RST = 1'h1;
    localparam logic [10:0] LFSR_SEED = 11'h7FF;
    // counts in line-clock ticks
    localparam logic [3:0] SYM100_LAST = 4'h4;
    localparam logic [3:0] SYM10_LAST = 4'h7;
    localparam logic [3:0] SQE_TICKS = 4'hA;
    // line levels: p/n pair, 11 marks frame end
    typedef struct packed {logic p; logic n;} phm_line_t;
    typedef struct packed {logic txEn; logic [3:0] txd;} phm_mii_tx_t;
    typedef struct packed {logic [3:0] rxd; logic rxDv; logic crs; logic col;} phm_mii_rx_t;
    typedef struct packed {
        logic rxAct; logic txActive; logic col; logic crs; logic [3:0] partner;
        logic mod10On; logic mod100On; logic fullDup; logic speed100;
    } phm_status_t;
    typedef struct packed {
        logic wrPend; logic [7:0] wrAddr; logic [31:0] hrdata;
        logic anEnable; logic ctlSpeed100; logic ctlFullDup; logic [3:0] adv;
        logic ps100; logic ps10;
        logic lineS1; logic lineS2; logic linePrev;
        phm_mii_tx_t txS1; phm_mii_tx_t txS2;
        phm_line_t rxLineS1; phm_line_t rxLineS2;
        logic [3:0] partS1; logic [3:0] partS2;
        logic speed100; logic fullDup; logic mod100On; logic mod10On;
        logic txActive; logic txStop; logic txReq; logic [4:0] txSh; logic [3:0] txCnt;
        logic [10:0] txLfsr; logic [1:0] mlt; phm_line_t txLine; logic [3:0] sqeCnt;
        logic rxAct; logic [4:0] rxSh; logic [3:0] rxCnt; logic [10:0] rxLfsr;
        phm_line_t rxPrev; logic [3:0] rxd; logic rxDv; logic crs; logic col;
    } phm_state_t;
endpackage

// >>> tb/phm_mac_model.sv
// behavioural mac that hands nibbles to the phy on each nibble request
`timescale 1ns/1ps
module phm_mac_model (
    input wire logic mclk,
    input wire logic rstn,
    input wire logic go,
    input wire logic [15:0] frame,
    input wire logic [2:0] len,
    input wire logic txNibbleReq,
    output phm_pkg::phm_mii_tx_t miiTx,
    output logic busy
);
    logic [15:0] sh;
    logic [2:0] cnt;
    // next nibble goes up right after each request, so it is stable across the next tick
    always @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            miiTx <= '0;
            busy <= 1'b0;
            sh <= 16'h0000;
            cnt <= 3'h0;
        end else if (go && !busy) begin
            busy <= 1'b1;
            sh <= frame << 4;
            cnt <= 3'h1;
            miiTx <= {1'b1, frame[15:12]};
        end else if (busy && txNibbleReq) begin
            sh <= sh << 4;
            cnt <= cnt + 3'h1;
            // idle txd flips, so a stale nibble can never pass for fresh data
            if (cnt == len) begin
                busy <= 1'b0;
                miiTx <= {1'b0, ~miiTx.txd};
            end else begin
                miiTx <= {1'b1, sh[15:12]};
            end
        end
    end
endmodule

// >>> tb/phm_mode_ctrl_bench.sv
// self-checking bench for the phy mode, duplex and power-save block
`timescale 1ns/1ps
module phm_mode_ctrl_bench;
    typedef struct packed {logic [15:0] ctrl; logic [1:0] ps; logic [3:0] part; logic [3:0] exp;} phm_row_t;
    logic mclk = 1'b0;
    logic rstn = 1'b0;
    logic lineClk = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    logic hreadyout, hresp, txNibbleReq, mod100On, mod10On, linkSpeed100, linkFullDup;
    logic [31:0] hrdata;
    logic [3:0] partnerAbil = 4'h0;
    phm_pkg::phm_mii_tx_t miiTx;
    phm_pkg::phm_mii_rx_t miiRx;
    phm_pkg::phm_line_t lineRx, lineTx;
    phm_pkg::phm_line_t rxForce = 2'h0;
    logic loopSel = 1'b0;
    logic go = 1'b0;
    logic [15:0] frame = 16'h0;
    logic [2:0] len = 3'h1;
    logic mBusy, capOn = 1'b0, sawCrs, sawCol, prevDv;
    logic [3:0] prevRxd;
    logic [3:0] rxQ [$];
    phm_pkg::phm_line_t lineQ [$];
    int err_count = 0;
    int checks = 0;
    logic [31:0] d;
    // manchester image of nibble A, led by the start marker level
    localparam logic [17:0] MAN_A = 18'h26969;
    // mode rows: control word, power-save bits, partner abilities, {mod10,mod100,fd,spd}
    phm_row_t rows [9] = '{'{16'h1000, 2'h3, 4'h8, 4'h7}, '{16'h1000, 2'h3, 4'h2, 4'hA},
        '{16'h1000, 2'h0, 4'h2, 4'hE}, '{16'h1000, 2'h1, 4'h4, 4'hD},
        '{16'h1000, 2'h2, 4'h1, 4'hC}, '{16'h1000, 2'h3, 4'h6, 4'h5},
        '{16'h1000, 2'h3, 4'h0, 4'h8}, '{16'h2100, 2'h3, 4'h1, 4'h7},
        '{16'h0000, 2'h3, 4'hF, 4'h8}};

    // clocks: line clock free running and out of phase with mclk
    always #20 mclk = ~mclk;
    initial begin
        #7;
        forever #160 lineClk = ~lineClk;
    end
    // far end either idles, forces a level, or is the cable looped back
    assign lineRx = loopSel ? lineTx : rxForce;

    phm_mode_ctrl uut (.mclk(mclk), .rstn(rstn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .lineClk(lineClk),
        .miiTx(miiTx), .txNibbleReq(txNibbleReq), .miiRx(miiRx), .lineRx(lineRx),
        .lineTx(lineTx), .partnerAbil(partnerAbil), .mod100On(mod100On), .mod10On(mod10On),
        .linkSpeed100(linkSpeed100), .linkFullDup(linkFullDup));
    phm_mac_model mac (.mclk(mclk), .rstn(rstn), .go(go), .frame(frame), .len(len),
        .txNibbleReq(txNibbleReq), .miiTx(miiTx), .busy(mBusy));

    // sticky status flags and received nibbles while a case runs
    always @(posedge mclk) begin
        if (capOn) begin
            if (miiRx.crs === 1'b1) sawCrs <= 1'b1;
            if (miiRx.col === 1'b1) sawCol <= 1'b1;
            if (miiRx.rxDv === 1'b1 && (prevDv !== 1'b1 || miiRx.rxd !== prevRxd)) rxQ.push_back(miiRx.rxd);
        end
        prevDv <= miiRx.rxDv;
        prevRxd <= miiRx.rxd;
    end
    // mid-tick sampling keeps clear of the 2-3 mclk update lag
    always @(negedge lineClk) begin
        if (capOn && (lineQ.size() > 0 || lineTx !== 2'b00)) lineQ.push_back(lineTx);
    end

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic wait_rdy;
        int n;
        n = 0;
        do begin
            @(posedge mclk);
            n++;
        end while (hreadyout !== 1'b1 && n < 50);
        if (n >= 50) chk("hready", 32'h0, 32'h1);
    endtask
    task automatic bus_addr(input logic [7:0] a, input logic wr);
        @(posedge mclk);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= 2'b10;
        hwrite <= wr;
        hsize <= 3'b010;
        wait_rdy();
        htrans <= 2'b00;
        hsel <= 1'b0;
    endtask
    task automatic bus_wr(input logic [7:0] a, input logic [31:0] v);
        bus_addr(a, 1'b1);
        hwdata <= v;
        wait_rdy();
    endtask
    task automatic bus_rd(input logic [7:0] a, output logic [31:0] v);
        bus_addr(a, 1'b0);
        wait_rdy();
        v = hrdata;
        chk("hresp", {31'h0, hresp}, 32'h0);
    endtask
    // mode settles within four cycles; a little margin for the sync stages
    task automatic settle;
        repeat (8) @(posedge mclk);
    endtask
    // idle means mac done, line quiet, no receive and no collision for 120 cycles
    task automatic wait_quiet;
        int q, n;
        q = 0;
        n = 0;
        while (q < 120 && n < 8000) begin
            @(posedge mclk);
            n++;
            if (!mBusy && lineTx === 2'b00 && miiRx.rxDv === 1'b0 && miiRx.col === 1'b0) q++;
            else q = 0;
        end
        if (n >= 8000) chk("quiet wait", 32'h0, 32'h1);
    endtask
    task automatic start_frame(input logic [15:0] frm, input logic [2:0] n);
        frame <= frm;
        len <= n;
        go <= 1'b1;
        @(posedge mclk);
        go <= 1'b0;
        @(posedge mclk);
    endtask
    task automatic frame_case(input string nm, input logic [15:0] ctrl, input logic loop,
            input logic [15:0] frm, input logic [2:0] n, input logic [15:0] expRx,
            input logic [2:0] expN, input logic expCrs, input logic expCol);
        bus_wr(phm_pkg::ADDR_CTRL, {16'h0, ctrl});
        settle();
        loopSel <= loop;
        sawCrs <= 1'b0;
        sawCol <= 1'b0;
        rxQ.delete();
        lineQ.delete();
        capOn <= 1'b1;
        start_frame(frm, n);
        wait_quiet();
        capOn <= 1'b0;
        chk("crs seen", {31'h0, sawCrs}, {31'h0, expCrs});
        chk("col seen", {31'h0, sawCol}, {31'h0, expCol});
        chk("rx count", rxQ.size(), {29'h0, expN});
        foreach (rxQ[i]) chk("rx nibble", {28'h0, rxQ[i]}, {28'h0, expRx[15-4*i -: 4]});
        $display("test %s done", nm);
    endtask
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", checks, err_count);
        if (err_count == 0 && checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask

    // watchdog well beyond the few thousand cycles the cases need
    initial begin
        repeat (60000) @(posedge mclk);
        err_count++;
        end_of_test();
    end

    initial begin
        repeat (3) @(posedge mclk);
        rstn <= 1'b1;
        bus_rd(phm_pkg::ADDR_CTRL, d);
        chk("ctrl reset", d, 32'h0000_3000);
        bus_rd(phm_pkg::ADDR_ADV, d);
        chk("adv reset", d, 32'h0000_000F);
        bus_rd(phm_pkg::ADDR_EXT2, d);
        chk("ext2 reset", d, 32'h0000_0003);
        bus_wr(8'h08, 32'hFFFF_FFFF);
        bus_rd(8'h08, d);
        chk("unmapped", d, 32'h0);
        $display("test reset done");
        // mode table: power save, negotiation, forced mode
        foreach (rows[i]) begin
            bus_wr(phm_pkg::ADDR_EXT2, {30'h0, rows[i].ps});
            partnerAbil <= rows[i].part;
            bus_wr(phm_pkg::ADDR_CTRL, {16'h0, rows[i].ctrl});
            settle();
            chk("mode pins", {28'h0, mod10On, mod100On, linkFullDup, linkSpeed100}, {28'h0, rows[i].exp});
            bus_rd(phm_pkg::ADDR_STAT, d);
            chk("stat mode", {28'h0, d[3:0]}, {28'h0, rows[i].exp});
        end
        $display("test mode table done");
        frame_case("100M FD loop", 16'h2100, 1'b1, 16'h5A3C, 3'h4, 16'h5A3C, 3'h4, 1'b1, 1'b0);
        frame_case("10M FD loop", 16'h0100, 1'b1, 16'h5A3C, 3'h4, 16'h5A3C, 3'h4, 1'b1, 1'b0);
        frame_case("10M FD tx", 16'h0100, 1'b0, 16'hA000, 3'h1, 16'h0, 3'h0, 1'b0, 1'b0);
        frame_case("10M HD tx", 16'h0000, 1'b0, 16'hA000, 3'h1, 16'hA000, 3'h1, 1'b1, 1'b1);
        for (int i = 0; i < 9; i++) chk("line level", {30'h0, lineQ[i]}, {30'h0, MAN_A[17-2*i -: 2]});
        // half duplex overlap at 100M, where no sqe can mask the collision
        bus_wr(phm_pkg::ADDR_CTRL, 32'h0000_2000);
        settle();
        sawCol <= 1'b0;
        sawCrs <= 1'b0;
        rxForce <= 2'b10;
        capOn <= 1'b1;
        start_frame(16'h7000, 3'h1);
        for (int n = 0; n < 4000 && mBusy === 1'b1; n++) @(posedge mclk);
        rxForce <= 2'b11;
        repeat (20) @(posedge mclk);
        rxForce <= 2'b00;
        wait_quiet();
        capOn <= 1'b0;
        chk("overlap col", {31'h0, sawCol}, 32'h1);
        chk("overlap crs", {31'h0, sawCrs}, 32'h1);
        $display("test collision done");
        // mid-run reset: pins clear, control back to defaults, negotiation resumes
        rstn <= 1'b0;
        @(posedge mclk);
        chk("reset pins", {28'h0, mod10On, mod100On, linkFullDup, linkSpeed100}, 32'h0);
        rstn <= 1'b1;
        bus_rd(phm_pkg::ADDR_CTRL, d);
        chk("ctrl re-reset", d, 32'h0000_3000);
        settle();
        chk("mode re-reset", {28'h0, mod10On, mod100On, linkFullDup, linkSpeed100}, 32'h7);
        $display("test mid reset done");
        end_of_test();
    end
endmodule
